/* rcap_board.sv */
`timescale 1ns/100ps
module rcap_board (
    input  wire logic       pclk,
    output logic      [6:0] pin
);
    // 0 gpi, 1 aux reset_n, 2 power lost (low), 3 test, 4 trip, 5 hot, 6 nand result
    initial pin = 7'h06;
    // one board line changes just after an edge
    task automatic put(input int i, input logic v);
        @(posedge pclk);
        pin[i] <= v;
    endtask
endmodule

/* rcap_pkg.sv */
package rcap_pkg;
    // register byte addresses
    localparam logic [7:0] RCAP_CFG_ADDR    = 8'h00;
    localparam logic [7:0] RCAP_STAT_ADDR   = 8'h04;
    localparam logic [7:0] RCAP_MASK_ADDR   = 8'h08;
    localparam logic [7:0] RCAP_REMOTE_ADDR = 8'h0c;
    localparam logic [7:0] RCAP_ALERT_ADDR  = 8'h10;
    localparam logic [7:0] RCAP_FAN_ADDR    = 8'h14;
    // configuration fields
    localparam int RCAP_CFG_INT_EN  = 1;
    localparam int RCAP_CFG_GPI_POL = 2;
    localparam int RCAP_CFG_FAN_OFF = 3;
    // status / mask fields
    localparam int RCAP_ST_TRIP     = 0;
    localparam int RCAP_ST_HWTRIP   = 1;
    localparam int RCAP_ST_GPI      = 4;
    // remote function fields
    localparam int RCAP_RF_RESET    = 0;
    localparam int RCAP_RF_OFF      = 1;
    // reset values and full fan speed
    localparam logic [7:0] RCAP_CFG_RST  = 8'h00;
    localparam logic [7:0] RCAP_MASK_RST = 8'h00;
    localparam logic [7:0] RCAP_FAN_RST  = 8'h00;
    localparam logic [7:0] RCAP_FAN_FULL = 8'hff;
    // timing
    localparam int RCAP_CLK_HZ        = 10_000_000;
    localparam int RCAP_PULSE_US      = 100;
    localparam int RCAP_PULSE_CYCLES  = RCAP_PULSE_US * (RCAP_CLK_HZ / 1_000_000);
endpackage

/* rcap_properties.sv */
`timescale 1ns/100ps
module rcap_properties
    import rcap_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       auxiliary_reset_n_in,
    input wire logic       main_power_lost_n_in,
    input wire logic       fan_speed_test_in,
    input wire logic       setpoint_exceeded_in,
    input wire logic       nand_tree_result_in,
    input wire logic       remote_power_off_out,
    input wire logic       over_temp_primary_out,
    input wire logic       over_temp_primary_oe,
    input wire logic       over_temp_secondary_oe,
    input wire logic [7:0] fan_speed_out,
    input wire logic       fan_speed_out_en
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ans_once_a: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    mirror_b_a: assert property (fan_speed_out_en |->
        over_temp_primary_oe == over_temp_secondary_oe) else $error("alarm outputs differ");
    hot_trip_a: assert property ($rose(setpoint_exceeded_in) |->
        ##[1:3] over_temp_secondary_oe) else $error("no alarm on setpoint");
    hot_full_a: assert property ((over_temp_secondary_oe && main_power_lost_n_in)[*5] |->
        fan_speed_out == RCAP_FAN_FULL) else $error("fan not full while hot");
    lost_off_a: assert property ((!main_power_lost_n_in && !over_temp_secondary_oe)[*5] |->
        fan_speed_out == 8'h00 && !remote_power_off_out) else $error("power lost ignored");
    nand_out_a: assert property (!fan_speed_out_en && $past(!fan_speed_out_en) |->
        over_temp_primary_out == $past(nand_tree_result_in)) else $error("nand result wrong");
    test_sel_a: assert property (fan_speed_test_in[*4] |-> !fan_speed_out_en)
        else $error("test mode not entered");
    fan_mode_a: assert property ((!fan_speed_test_in && auxiliary_reset_n_in)[*4] |->
        fan_speed_out_en && !over_temp_primary_out) else $error("fan output not enabled");
    roff_hold_a: assert property ($fell(remote_power_off_out) |->
        !$past(main_power_lost_n_in, 3) || !$past(auxiliary_reset_n_in, 3))
        else $error("power-off dropped early");
    cover property (remote_power_off_out);
    cover property (!fan_speed_out_en ##1 fan_speed_out_en);
    cover property (over_temp_secondary_oe && fan_speed_out == RCAP_FAN_FULL);
endmodule
bind rcap_top rcap_properties u_props (.*);

/* rcap_sync.sv */
`timescale 1ns/100ps
module rcap_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

/* rcap_top.sv */
// Operation
// - fan off request drives open-drain pin low, independent of fan speed
// - released fan off pin means fan may run
// - general input has programmable polarity; active sets status bit 4
// - auxiliary reset input low resets the registers and the remote reset pulse
// - main power lost low: fan speed off, remote power-off cleared
// - remote reset open-drain output pulses low on remote message
// - high on fan speed/test pin selects nand tree test mode
// - outside test mode the pin is the fan speed output
// - primary over-temperature output low while setpoint exceeded
// - fan commanded full speed while setpoint exceeded, unless main power lost
// - in test mode primary over-temperature output carries nand tree result
// - secondary open-drain over-temperature output mirrors the primary indication outside test mode
// - remote power-off output driven high on remote message
// - remote power-off and its bit stay high until power lost or auxiliary reset
// - interrupt output signals violated trip point
// - interrupt output enabled only by config bit 1, disabled after reset
// - remote function register writes trigger remote reset and power-off
// - interrupt mask register suppresses each source individually
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
module rcap_top
    import rcap_pkg::*;
#(
    parameter int PULSE_CYCLES = RCAP_PULSE_CYCLES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        general_input_pin,
    input  wire logic        auxiliary_reset_n_in,
    input  wire logic        main_power_lost_n_in,
    input  wire logic        fan_speed_test_in,
    input  wire logic        trip_violation_in,
    input  wire logic        setpoint_exceeded_in,
    input  wire logic        nand_tree_result_in,
    output logic             fan_off_oe,
    output logic             remote_reset_oe,
    output logic             remote_power_off_out,
    output logic             over_temp_primary_out,
    output logic             over_temp_primary_oe,
    output logic             over_temp_secondary_oe,
    output logic             int_oe,
    output logic [7:0]       fan_speed_out,
    output logic             fan_speed_out_en
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and internal reset

    logic [4:0] pins_s;
    logic       gpi_s;
    logic       aux_n_s;
    logic       pwr_n_s;
    logic       test_s;
    logic       trip_s;
    logic       blk_rstn;

    rcap_sync #(.W(5)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({general_input_pin, auxiliary_reset_n_in, main_power_lost_n_in,
                   fan_speed_test_in, trip_violation_in}),
        .q       (pins_s)
    );

    assign gpi_s   = pins_s[4];
    assign aux_n_s = pins_s[3];
    assign pwr_n_s = pins_s[2];
    assign test_s  = pins_s[1];
    assign trip_s  = pins_s[0];

    // synchronised aux reset acts as a synchronous reset of the registers and pulse counter
    assign blk_rstn = aux_n_s;

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    logic       wr_en;
    logic       rd_en;
    logic       hit_cfg;
    logic       hit_stat;
    logic       hit_mask;
    logic       hit_remote;
    logic       hit_alert;
    logic       hit_fan;
    logic       hit_any;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    assign hit_cfg    = addr_is(paddr, RCAP_CFG_ADDR);
    assign hit_stat   = addr_is(paddr, RCAP_STAT_ADDR);
    assign hit_mask   = addr_is(paddr, RCAP_MASK_ADDR);
    assign hit_remote = addr_is(paddr, RCAP_REMOTE_ADDR);
    assign hit_alert  = addr_is(paddr, RCAP_ALERT_ADDR);
    assign hit_fan    = addr_is(paddr, RCAP_FAN_ADDR);
    assign hit_any    = hit_cfg | hit_stat | hit_mask | hit_remote | hit_alert | hit_fan;
    assign wr_en      = psel & penable & pwrite & pstrb[0] & hit_any;
    assign rd_en      = psel & ~penable & ~pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic [7:0] stat_reg;
    logic [7:0] stat_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [7:0] fan_reg;
    logic [7:0] fan_next;
    logic       roff_reg;
    logic       roff_next;
    logic       gpi_act;
    logic       pwr_lost;
    logic       hot;
    logic       rf_reset_go;
    logic       rf_off_go;
    logic       stat_clr_go;
    logic [7:0] stat_set;

    assign pwr_lost    = ~pwr_n_s;
    assign hot         = setpoint_exceeded_in;
    assign gpi_act     = gpi_s ^ ~cfg_reg[RCAP_CFG_GPI_POL];
    assign rf_reset_go = wr_en & hit_remote & pwdata[RCAP_RF_RESET];
    assign rf_off_go   = wr_en & hit_remote & pwdata[RCAP_RF_OFF];
    assign stat_clr_go = wr_en & hit_stat;

    // plain read/write registers
    assign cfg_next  = (wr_en & hit_cfg) ? pwdata[7:0] : cfg_reg;
    assign mask_next = (wr_en & hit_mask) ? pwdata[7:0] : mask_reg;
    assign fan_next  = (wr_en & hit_fan) ? pwdata[7:0] : fan_reg;

    always_comb begin
        stat_set                 = 8'h00;
        stat_set[RCAP_ST_GPI]    = gpi_act;
        stat_set[RCAP_ST_TRIP]   = trip_s;
        stat_set[RCAP_ST_HWTRIP] = hot;
    end

    // per bit write-one-to-clear, new events win over the clear
    for (genvar i = 0; i < 8; i++) begin : g_stat
        assign stat_next[i] = stat_set[i] | (stat_reg[i] & ~(stat_clr_go & pwdata[i]));
    end

    // set by message, held until power lost or reset, which win
    assign roff_next = (pwr_lost | ~blk_rstn) ? 1'b0 : (roff_reg | rf_off_go);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= RCAP_CFG_RST;
        end else if (!blk_rstn) begin
            cfg_reg <= RCAP_CFG_RST;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_reg <= 8'h00;
        end else if (!blk_rstn) begin
            stat_reg <= 8'h00;
        end else begin
            stat_reg <= stat_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= RCAP_MASK_RST;
        end else if (!blk_rstn) begin
            mask_reg <= RCAP_MASK_RST;
        end else begin
            mask_reg <= mask_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_reg <= RCAP_FAN_RST;
        end else if (!blk_rstn) begin
            fan_reg <= RCAP_FAN_RST;
        end else begin
            fan_reg <= fan_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            roff_reg <= 1'b0;
        end else if (!blk_rstn) begin
            roff_reg <= 1'b0;
        end else begin
            roff_reg <= roff_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // remote reset pulse

    logic [$clog2(PULSE_CYCLES+1)-1:0] pulse_cnt_reg;
    logic                              pulse_active;

    assign pulse_active = pulse_cnt_reg != '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_cnt_reg <= '0;
        end else if (!blk_rstn) begin
            pulse_cnt_reg <= '0;
        end else if (rf_reset_go) begin
            pulse_cnt_reg <= PULSE_CYCLES[$clog2(PULSE_CYCLES+1)-1:0];
        end else if (pulse_active) begin
            pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin outputs

    logic       int_req;
    logic       temp_alarm;
    logic [7:0] fan_drive;
    logic [7:0] alert_word;
    logic [7:0] rd_mux;

    assign int_req    = |(stat_reg & ~mask_reg);
    assign temp_alarm = hot;
    assign fan_drive  = pwr_lost ? RCAP_FAN_RST :
                        temp_alarm ? RCAP_FAN_FULL : fan_reg;
    assign alert_word = {3'b000, gpi_s, 1'b0, roff_reg, trip_s, temp_alarm};

    assign rd_mux = hit_cfg    ? cfg_reg :
                    hit_stat   ? stat_reg :
                    hit_mask   ? mask_reg :
                    hit_remote ? {6'b000000, roff_reg, pulse_active} :
                    hit_alert  ? alert_word :
                    hit_fan    ? fan_reg : 8'h00;

    logic       prim_out_next;
    logic       prim_oe_next;
    logic       int_next;
    logic       err_next;
    logic [31:0] rdata_next;

    // test mode hands the primary pin to the nand tree result
    assign prim_out_next = test_s ? nand_tree_result_in : 1'b0;
    assign prim_oe_next  = test_s ? ~nand_tree_result_in : temp_alarm;
    assign int_next      = cfg_reg[RCAP_CFG_INT_EN] & int_req;
    assign err_next      = psel & ~penable & pwrite & ~hit_any;
    assign rdata_next    = rd_en ? {24'h000000, rd_mux} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_off_oe           <= 1'b0;
            remote_reset_oe      <= 1'b0;
            remote_power_off_out <= 1'b0;
        end else begin
            fan_off_oe           <= cfg_reg[RCAP_CFG_FAN_OFF];
            remote_reset_oe      <= pulse_active;
            remote_power_off_out <= roff_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            over_temp_primary_out  <= 1'b0;
            over_temp_primary_oe   <= 1'b0;
            over_temp_secondary_oe <= 1'b0;
        end else begin
            over_temp_primary_out  <= prim_out_next;
            over_temp_primary_oe   <= prim_oe_next;
            over_temp_secondary_oe <= temp_alarm;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_oe <= 1'b0;
        end else begin
            int_oe <= int_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_speed_out    <= 8'h00;
            fan_speed_out_en <= 1'b0;
        end else begin
            fan_speed_out    <= fan_drive;
            fan_speed_out_en <= ~test_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb response, one access cycle after setup

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= rdata_next;
            pready  <= psel & ~penable;
            pslverr <= err_next;
        end
    end

endmodule

/* tb_remote_control_alert_pins.sv */
`timescale 1ns/100ps
module tb_remote_control_alert_pins;
    import rcap_pkg::*;
    localparam int PW = 5;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata, exp_q[$];
    logic        err_q[$];
    logic [7:0]  fan_speed_out, v;
    logic        pready, pslverr, fan_off_oe, remote_reset_oe, remote_power_off_out, int_oe;
    logic        over_temp_primary_out, over_temp_primary_oe, over_temp_secondary_oe;
    logic        fan_speed_out_en;
    logic [6:0]  pin;
    wire         general_input_pin, auxiliary_reset_n_in, main_power_lost_n_in;
    wire         fan_speed_test_in, trip_violation_in, setpoint_exceeded_in, nand_tree_result_in;
    int          n_fail = 0, n_tests = 0, cyc = 0, seed = 17, n;
    assign {nand_tree_result_in, setpoint_exceeded_in, trip_violation_in, fan_speed_test_in,
            main_power_lost_n_in, auxiliary_reset_n_in, general_input_pin} = pin;
    // pin levels with board pull-ups
    wire fan_off_n = !fan_off_oe;
    wire rrst_n    = !remote_reset_oe;
    wire int_n     = !int_oe;
    wire otb_n     = !over_temp_secondary_oe;
    wire ota_n     = over_temp_primary_oe ? over_temp_primary_out : 1'h1;
    rcap_top #(.PULSE_CYCLES(PW)) u_dut (.*);
    rcap_board u_board (.pclk(pclk), .pin(pin));
    always #50 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic pin_is(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        err_q.push_back(w && !(a inside {RCAP_CFG_ADDR, RCAP_STAT_ADDR, RCAP_MASK_ADDR,
                                         RCAP_REMOTE_ADDR, RCAP_ALERT_ADDR, RCAP_FAN_ADDR}));
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (!pready);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'h1, a, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        apb(1'h0, a, 32'h0);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
        if (psel && penable && pready && !pwrite) begin
            chk(prdata, exp_q.pop_front());
        end
        if (psel && penable && pready) begin
            pin_is(pslverr, err_q.pop_front());
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        rd(RCAP_CFG_ADDR, RCAP_CFG_RST);
        rd(RCAP_MASK_ADDR, RCAP_MASK_RST);
        rd(RCAP_REMOTE_ADDR, 8'h00);
        wr(8'h20, 8'h5a);
        for (int i = 0; i < 3; i++) begin
            v = 8'($random(seed));
            wr(RCAP_FAN_ADDR, v);
            rd(RCAP_FAN_ADDR, v);
            chk({24'h0, fan_speed_out}, {24'h0, v});
        end
        wr(RCAP_CFG_ADDR, 8'h08);
        idle(2);
        pin_is(fan_off_n, 1'h0);
        chk({24'h0, fan_speed_out}, {24'h0, v});
        wr(RCAP_CFG_ADDR, 8'h00);
        idle(2);
        pin_is(fan_off_n, 1'h1);
        $display("reset values and fan control done");
        for (int p = 0; p < 2; p++) begin
            wr(RCAP_CFG_ADDR, {5'h0, p[0], 2'h0});
            u_board.put(0, p[0]);
            idle(4);
            wr(RCAP_STAT_ADDR, 8'hff);
            rd(RCAP_STAT_ADDR, 8'h10);
            u_board.put(0, !p[0]);
            idle(4);
            wr(RCAP_STAT_ADDR, 8'hff);
            rd(RCAP_STAT_ADDR, 8'h00);
        end
        $display("general input done");
        u_board.put(4, 1'h1);
        idle(4);
        pin_is(int_n, 1'h1);
        wr(RCAP_CFG_ADDR, 8'h06);
        idle(2);
        pin_is(int_n, 1'h0);
        wr(RCAP_MASK_ADDR, 8'h01);
        idle(2);
        pin_is(int_n, 1'h1);
        u_board.put(4, 1'h0);
        idle(3);
        wr(RCAP_STAT_ADDR, 8'hff);
        wr(RCAP_MASK_ADDR, 8'h00);
        idle(2);
        pin_is(int_n, 1'h1);
        $display("interrupt done");
        wr(RCAP_REMOTE_ADDR, 8'h01);
        n = 0;
        repeat (PW + 6) begin
            @(posedge pclk);
            n += int'(!rrst_n);
        end
        chk(32'(n), 32'(PW));
        wr(RCAP_REMOTE_ADDR, 8'h02);
        idle(3);
        pin_is(remote_power_off_out, 1'h1);
        wr(RCAP_REMOTE_ADDR, 8'h00);
        rd(RCAP_REMOTE_ADDR, 8'h02);
        u_board.put(2, 1'h0);
        idle(5);
        pin_is(remote_power_off_out, 1'h0);
        rd(RCAP_REMOTE_ADDR, 8'h00);
        chk({24'h0, fan_speed_out}, 32'h0);
        u_board.put(2, 1'h1);
        idle(3);
        wr(RCAP_REMOTE_ADDR, 8'h02);
        idle(3);
        pin_is(remote_power_off_out, 1'h1);
        u_board.put(1, 1'h0);
        idle(5);
        pin_is(remote_power_off_out, 1'h0);
        wr(RCAP_CFG_ADDR, 8'h0f);
        u_board.put(1, 1'h1);
        idle(4);
        rd(RCAP_CFG_ADDR, 8'h00);
        $display("remote functions done");
        u_board.put(5, 1'h1);
        idle(4);
        pin_is(otb_n, 1'h0);
        pin_is(ota_n, 1'h0);
        chk({24'h0, fan_speed_out}, {24'h0, RCAP_FAN_FULL});
        u_board.put(5, 1'h0);
        u_board.put(3, 1'h1);
        for (int r = 0; r < 2; r++) begin
            u_board.put(6, r[0]);
            idle(4);
            pin_is(ota_n, r[0]);
            pin_is(fan_speed_out_en, 1'h0);
        end
        u_board.put(6, 1'h0);
        u_board.put(3, 1'h0);
        idle(4);
        pin_is(fan_speed_out_en, 1'h1);
        $display("over-temperature and test mode done");
        idle(2);
        report_and_stop();
    end
endmodule
